// ===== rtl/shutdown_cause_and_rail_voltage_regs.sv
// Shutdown cause register and two regulator control registers
`timescale 1ns/1ps
`default_nettype none
module shutdown_cause_and_rail_voltage_regs (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic undervoltage_shutdown_i,
  input wire logic rail_fault_shutdown_i,
  input wire logic critical_heat_shutdown_i,
  output logic [7:0] rdata_o,
  output logic [3:0] shutdown_cause_o,
  output logic shutdown_indication_set_o,
  output logic shutdown_clear_allowed_o,
  output logic [6:0] first_rail_voltage_code_o,
  output logic first_rail_decay_select_o,
  output logic [6:0] second_rail_voltage_code_o,
  output logic second_rail_decay_select_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] rdata;
    logic [7:0] first_ctrl;
    logic [7:0] second_ctrl;
    logic ind_set;
    logic clr_ok;
  } state_type;

  state_type state_q;
  state_type state_d;

  // ----------------------------------------------------------------
  // Internal signals
  // ----------------------------------------------------------------
  // Per-cause set requests from the shutdown sequencer
  logic [3:0] flag_set;
  // Per-cause clear requests from a host write of ones
  logic [3:0] flag_clr;
  // Cause flags as held in the flag bank
  logic [3:0] flags;
  // Register selects for the current bus cycle
  logic sel_cause;
  logic sel_first;
  logic sel_second;
  // Write strobes qualified by the register selects
  logic wr_cause;
  logic wr_first;
  logic wr_second;
  // Cause flags that go from clear to set at the next edge
  logic [2:0] rising;
  // Word to load into the read data register
  logic [7:0] read_word;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  // Address match against one register offset
  function automatic logic hit(
    input logic [7:0] a,
    input logic [7:0] r
  );
    hit = (a == r);
  endfunction : hit

  // Cause register as the host sees it, reserved bits zero
  function automatic logic [7:0] cause_word(
    input logic [3:0] f
  );
    cause_word = {4'h0, f};
  endfunction : cause_word

  // Voltage code field of a regulator control register
  function automatic logic [6:0] code_field(
    input logic [7:0] r
  );
    code_field = r[7:shutdown_regs_pkg::CODE_LSB];
  endfunction : code_field

  // Decay select field of a regulator control register
  function automatic logic decay_field(
    input logic [7:0] r
  );
    decay_field = r[shutdown_regs_pkg::DECAY_BIT];
  endfunction : decay_field

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  always_comb begin
    sel_cause = hit(addr_i, shutdown_regs_pkg::SHUTDOWN_CAUSE_ADDR);
    sel_first = hit(addr_i, shutdown_regs_pkg::FIRST_REG_CTRL_ADDR);
    sel_second = hit(addr_i, shutdown_regs_pkg::SECOND_REG_CTRL_ADDR);
    wr_cause = wr_en_i && sel_cause;
    wr_first = wr_en_i && sel_first;
    wr_second = wr_en_i && sel_second;
  end

  // ----------------------------------------------------------------
  // Cause flags
  // ----------------------------------------------------------------
  // Set requests are level sensitive: an event held high keeps its
  // flag set even against a host clear in the same cycle.
  always_comb begin
    flag_set = '0;
    flag_set[shutdown_regs_pkg::UNDERVOLT_BIT] = undervoltage_shutdown_i;
    flag_set[shutdown_regs_pkg::RAIL_FAULT_BIT] = rail_fault_shutdown_i;
    flag_set[shutdown_regs_pkg::CRIT_HEAT_BIT] = critical_heat_shutdown_i;
    flag_set[shutdown_regs_pkg::COLD_OFF_BIT] = 1'b0;
    flag_clr = '0;
    if (wr_cause) begin
      // Reserved upper bits of the write are dropped here
      flag_clr = wdata_i[3:0];
    end
  end

  cause_flag_bank u_flags (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .set_i(flag_set),
    .clear_i(flag_clr),
    .flags_o(flags)
  );

  // Only a clear-to-set change counts, so a held event gives one pulse
  always_comb begin
    rising = flag_set[2:0] & ~flags[2:0];
  end

  // ----------------------------------------------------------------
  // Read multiplexer
  // ----------------------------------------------------------------
  // Unmapped offsets read as zero; a read in the same cycle as a
  // write returns the value from before the write.
  always_comb begin
    read_word = 8'h00;
    if (sel_cause) begin
      read_word = cause_word(flags);
    end else if (sel_first) begin
      read_word = state_q.first_ctrl;
    end else if (sel_second) begin
      read_word = state_q.second_ctrl;
    end
  end

  // ----------------------------------------------------------------
  // Register access
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    // Pulse marks a cause flag rising, for the interrupt register
    state_d.ind_set = |rising;
    // Host may clear the indication only once all causes are clear
    state_d.clr_ok = ~|(flags & shutdown_regs_pkg::CAUSE_FLAGS_MASK);
    if (wr_first) begin
      state_d.first_ctrl = wdata_i;
    end
    if (wr_second) begin
      state_d.second_ctrl = wdata_i;
    end
    if (rd_en_i) begin
      state_d.rdata = read_word;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q.rdata <= 8'h00;
      state_q.first_ctrl <= shutdown_regs_pkg::FIRST_REG_CTRL_RESET;
      state_q.second_ctrl <= shutdown_regs_pkg::SECOND_REG_CTRL_RESET;
      state_q.ind_set <= 1'b0;
      state_q.clr_ok <= 1'b1;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rdata_o = state_q.rdata;
  assign shutdown_cause_o = flags;
  assign shutdown_indication_set_o = state_q.ind_set;
  assign shutdown_clear_allowed_o = state_q.clr_ok;
  assign first_rail_voltage_code_o = code_field(state_q.first_ctrl);
  assign first_rail_decay_select_o = decay_field(state_q.first_ctrl);
  assign second_rail_voltage_code_o = code_field(state_q.second_ctrl);
  assign second_rail_decay_select_o = decay_field(state_q.second_ctrl);

endmodule : shutdown_cause_and_rail_voltage_regs
`default_nettype wire

// ===== rtl/shutdown_regs_pkg.sv
// Constants for the shutdown cause and rail voltage registers
package shutdown_regs_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] SHUTDOWN_CAUSE_ADDR = 8'h05;
  localparam logic [7:0] FIRST_REG_CTRL_ADDR = 8'h20;
  localparam logic [7:0] SECOND_REG_CTRL_ADDR = 8'h21;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CRIT_HEAT_BIT = 0;
  localparam int RAIL_FAULT_BIT = 1;
  localparam int UNDERVOLT_BIT = 2;
  localparam int COLD_OFF_BIT = 3;
  localparam int DECAY_BIT = 0;
  localparam int CODE_LSB = 1;
  localparam logic [7:0] SHUTDOWN_CAUSE_RESET = 8'h00;
  localparam logic [3:0] CAUSE_FLAGS_MASK = 4'h7;

  // Factory configuration defaults (arbitrary neutral values)
  localparam logic [7:0] FIRST_REG_CTRL_RESET = 8'h00;
  localparam logic [7:0] SECOND_REG_CTRL_RESET = 8'h00;

endpackage : shutdown_regs_pkg

// ===== rtl/cause_flag_bank.sv
// Sticky write-one-to-clear cause flags with set-over-clear priority
`timescale 1ns/1ps
`default_nettype none
module cause_flag_bank (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic [3:0] set_i,
  input wire logic [3:0] clear_i,
  output logic [3:0] flags_o
);

  typedef struct packed {
    logic [3:0] flags;
  } state_type;

  state_type state_q;
  state_type state_d;

  always_comb begin
    state_d = state_q;
    for (int i = 0; i < 4; i++) begin
      if (set_i[i]) begin
        state_d.flags[i] = 1'b1;
      end else if (clear_i[i]) begin
        state_d.flags[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign flags_o = state_q.flags;

endmodule : cause_flag_bank
`default_nettype wire

// ===== verification/shutdown_regs_properties.sv
// Port assertions for the shutdown cause and rail voltage registers
`timescale 1ns/1ps
`default_nettype none
module shutdown_regs_properties (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic undervoltage_shutdown_i,
  input wire logic rail_fault_shutdown_i,
  input wire logic critical_heat_shutdown_i,
  input wire logic [7:0] rdata_o,
  input wire logic [3:0] shutdown_cause_o,
  input wire logic shutdown_indication_set_o,
  input wire logic shutdown_clear_allowed_o,
  input wire logic [6:0] first_rail_voltage_code_o,
  input wire logic first_rail_decay_select_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  logic [2:0] ev;
  logic [3:0] clr;
  assign ev = {undervoltage_shutdown_i, rail_fault_shutdown_i,
    critical_heat_shutdown_i};
  assign clr = (wr_en_i && addr_i == 8'h05) ? wdata_i[3:0] : 4'h0;
  AST_COLD: assert property (shutdown_cause_o[3] == 1'b0)
    else $error("cold off flag set");
  AST_SET:
    assert property (|ev |=> (shutdown_cause_o[2:0] & $past(ev)) == $past(ev))
    else $error("cause flag not set");
  AST_IND:
    assert property ((shutdown_cause_o[2:0] & ~$past(shutdown_cause_o[2:0]))
      != 3'h0 |-> shutdown_indication_set_o) else $error("no indication");
  AST_STICKY:
    assert property (($past(shutdown_cause_o) & ~$past(clr)
      & ~shutdown_cause_o) == 4'h0) else $error("flag lost");
  AST_W1C:
    assert property (|clr |=> (shutdown_cause_o & $past(clr)
      & ~{1'b0, $past(ev)}) == 4'h0) else $error("flag not cleared");
  AST_CLR_OK:
    assert property (shutdown_clear_allowed_o
      == ($past(shutdown_cause_o) == 4'h0)) else $error("clear gate wrong");
  AST_CTRL:
    assert property (wr_en_i && addr_i == 8'h20 |=> {first_rail_voltage_code_o,
      first_rail_decay_select_o} == $past(wdata_i)) else $error("ctrl wrong");
  AST_READ:
    assert property (rd_en_i && addr_i == 8'h05 |=> rdata_o
      == {4'h0, $past(shutdown_cause_o)}) else $error("cause read wrong");
  cover property (shutdown_indication_set_o);
  cover property (|clr && |shutdown_cause_o);
  cover property (rd_en_i && addr_i == 8'h21);
endmodule : shutdown_regs_properties
`default_nettype wire

// ===== verification/host_bus_model.sv
// Host model issuing one register read or write per call
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
  input wire logic clk_sys_i,
  input wire logic [7:0] rdata_o,
  output logic wr_en_o,
  output logic rd_en_o,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o
);
  initial {wr_en_o, rd_en_o, addr_o, wdata_o} = 18'h0_0000;
  // Host clears a cause flag only by writing one to it
  task automatic access(input logic wr, input logic [7:0] a, d,
    output logic [7:0] q);
    @(posedge clk_sys_i);
    #1;
    {wr_en_o, rd_en_o, addr_o, wdata_o} = {wr, !wr, a, d};
    @(posedge clk_sys_i);
    #1;
    q = rdata_o;
    {wr_en_o, rd_en_o, addr_o, wdata_o} = {2'b00, ~a, ~d};
  endtask : access
endmodule : host_bus_model
`default_nettype wire

// ===== verification/testbench.sv
// Self-checking bench for the shutdown cause and rail voltage registers
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_sys_i, rst_b_i, wr_en_i, rd_en_i, ind_o, ok_o, dec1_o, dec2_o;
  logic [7:0] addr_i, wdata_i, rdata_o, q;
  logic [6:0] code1_o, code2_o;
  logic [3:0] shutdown_cause_o;
  logic [2:0] ev;
  int failures, checks;
  logic [7:0] rows [4][3] = '{'{8'h20, 8'hA5, 8'hA5}, '{8'h21, 8'h5A, 8'h5A},
    '{8'h05, 8'hF0, 8'h00}, '{8'h33, 8'hFF, 8'h00}};
  shutdown_cause_and_rail_voltage_regs i_dut (.clk_sys_i, .rst_b_i,
    .wr_en_i, .rd_en_i, .addr_i, .wdata_i, .rdata_o, .shutdown_cause_o,
    .undervoltage_shutdown_i(ev[2]), .rail_fault_shutdown_i(ev[1]),
    .critical_heat_shutdown_i(ev[0]), .shutdown_indication_set_o(ind_o),
    .shutdown_clear_allowed_o(ok_o), .first_rail_voltage_code_o(code1_o),
    .first_rail_decay_select_o(dec1_o), .second_rail_voltage_code_o(code2_o),
    .second_rail_decay_select_o(dec2_o));
  host_bus_model i_host (.clk_sys_i, .rdata_o, .wr_en_o(wr_en_i),
    .rd_en_o(rd_en_i), .addr_o(addr_i), .wdata_o(wdata_i));
  task automatic chk(input string n, input logic [7:0] e, s);
    checks++;
    if (s !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, s);
      failures++;
    end
  endtask : chk
  task automatic give_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    #5000;
    failures++;
    give_verdict();
  end
  initial begin
    rst_b_i = 1'b0;
    ev = 3'h0;
    repeat (20) @(posedge clk_sys_i);
    #1;
    rst_b_i = 1'b1;
    foreach (rows[i]) begin
      i_host.access(1'b0, rows[i][0], 8'h00, q);
      chk("reset read", 8'h00, q);
      i_host.access(1'b1, rows[i][0], rows[i][1], q);
      i_host.access(1'b0, rows[i][0], 8'h00, q);
      chk("read back", rows[i][2], q);
    end
    chk("ctrl1", 8'hA5, {code1_o, dec1_o});
    chk("ctrl2", 8'h5A, {code2_o, dec2_o});
    for (int b = 0; b < 3; b++) begin
      @(posedge clk_sys_i);
      #1;
      ev = 3'h1 << b;
      @(posedge clk_sys_i);
      #1;
      ev = 3'h0;
      chk("indication", 8'h01, {7'h00, ind_o});
      i_host.access(1'b1, 8'h05, 8'h00, q);
      chk("indication end", 8'h00, {7'h00, ind_o});
      chk("cause", 8'h01 << b, {4'h0, shutdown_cause_o});
      chk("clear gate", 8'h00, {7'h00, ok_o});
      i_host.access(1'b1, 8'h05, 8'h01 << b, q);
      chk("cleared", 8'h00, {4'h0, shutdown_cause_o});
    end
    ev = 3'h4;
    i_host.access(1'b1, 8'h05, 8'h04, q);
    chk("held event", 8'h04, {4'h0, shutdown_cause_o});
    ev = 3'h0;
    i_host.access(1'b1, 8'h05, 8'h0C, q);
    chk("cold off", 8'h00, {4'h0, shutdown_cause_o});
    @(posedge clk_sys_i);
    #1;
    chk("clear gate open", 8'h01, {7'h00, ok_o});
    i_host.access(1'b1, 8'h20, 8'h3C, q);
    ev = 3'h2;
    @(posedge clk_sys_i);
    #1;
    ev = 3'h0;
    rst_b_i = 1'b0;
    repeat (2) @(posedge clk_sys_i);
    #1;
    chk("reset cause", 8'h00, {4'h0, shutdown_cause_o});
    chk("reset gate", 8'h01, {7'h00, ok_o});
    chk("reset ctrl1", shutdown_regs_pkg::FIRST_REG_CTRL_RESET,
      {code1_o, dec1_o});
    chk("reset ctrl2", shutdown_regs_pkg::SECOND_REG_CTRL_RESET,
      {code2_o, dec2_o});
    rst_b_i = 1'b1;
    i_host.access(1'b0, 8'h05, 8'h00, q);
    chk("read after reset", 8'h00, q);
    give_verdict();
  end
endmodule : testbench
bind shutdown_cause_and_rail_voltage_regs shutdown_regs_properties i_props (
  .clk_sys_i, .rst_b_i, .wr_en_i, .rd_en_i, .addr_i, .wdata_i, .rdata_o,
  .undervoltage_shutdown_i, .rail_fault_shutdown_i, .critical_heat_shutdown_i,
  .shutdown_cause_o, .shutdown_indication_set_o, .shutdown_clear_allowed_o,
  .first_rail_voltage_code_o, .first_rail_decay_select_o);
`default_nettype wire
